// file: design/cct_defs.vh
`ifndef CCT_DEFS_VH
`define CCT_DEFS_VH

// register addresses on the internal byte bus
`define CCT_ADDR_CAPCMP_CTRL  16'hff33
`define CCT_ADDR_TIMER_CTRL   16'hff5f
`define CCT_ADDR_COUNT_LO     16'hff20
`define CCT_ADDR_COUNT_HI     16'hff21
`define CCT_ADDR_COMPARE_LO   16'hff22
`define CCT_ADDR_COMPARE_HI   16'hff23
`define CCT_ADDR_CAPCMP_LO    16'hff24
`define CCT_ADDR_CAPCMP_HI    16'hff25
`define CCT_ADDR_CAPTURE_LO   16'hff26
`define CCT_ADDR_CAPTURE_HI   16'hff27
`define CCT_ADDR_PRESCALER    16'hff28
`define CCT_ADDR_OUTCTL       16'hff29

// reset values
`define CCT_RST_TIMER_CTRL    8'h00
`define CCT_RST_CAPCMP_CTRL   8'h10
`define CCT_RST_PRESCALER     8'h11
`define CCT_RST_OUTCTL        8'h00

// timer_control fields
`define CCT_TC_WIDTH          4
`define CCT_TC_ONESHOT        5
`define CCT_TC_OVF            6
`define CCT_TC_ENABLE         7

// capture_compare_control fields
`define CCT_CC_CAPCMP_SEL     0
`define CCT_CC_MATCH_CLR      2
`define CCT_CC_CAPTURE_CLR    3
`define CCT_CC_MODE_LO        5
`define CCT_CC_MODE_HI        6

// output control fields (upper nibble)
`define CCT_OC_LEVEL_A        4
`define CCT_OC_ENABLE_A       5
`define CCT_OC_LEVEL_B        6
`define CCT_OC_ENABLE_B       7

// prescaler select codes
`define CCT_PRE_EXT_SEL       4'hf
`define CCT_PRE_MAX_SEL       4'h8

`endif

// file: design/cct_timer_core.v
// Operation
// - trigger a edge copies counter into capture
// - width bit picks 8 or 16 bits
// - edges give interrupts, captures, event clock
// - outputs invert on compare or capcmp match
// - output control upper nibble drives outputs
// - disabled outputs show fixed programmed level
// - count clock: prescaler or trigger b edge
// - counter and capture are read only
// - mode bit: normal or one shot
// - full count wraps, sets overflow flag
// - overflow flag cleared only by software
// - enable: clear on first tick, count after
// - disable: counter zero, captures, matches stop
// - rewriting enable one changes nothing
// - reset: counter zero, stopped, control defaults
// - auto clear waits for next count tick
// - match clear on capcmp compare match
// - capture clear after trigger a capture
// - output mode: toggle, pwm, ppg
// - compare match raises compare interrupt
// - one shot halts full, restarts on clear
`timescale 1ns/1ps
`include "cct_defs.vh"

module cct_timer_core (
   input  wire        core_clk,         // 200 MHz system clock
   input  wire        rst,              // async reset, active high
   input  wire [15:0] bus_addr,         // register byte address
   input  wire [7:0]  bus_wdata,        // write data
   input  wire        bus_wr,           // write strobe
   input  wire        bus_rd,           // read strobe
   output reg  [7:0]  bus_rdata,        // read data, one cycle later
   input  wire        trigger_input_a,  // external trigger pin a
   input  wire        trigger_input_b,  // external trigger pin b
   input  wire [1:0]  edge_sel_a,       // bit0 rising, bit1 falling
   input  wire [1:0]  edge_sel_b,       // bit0 rising, bit1 falling
   output reg         irq_trigger_a,    // edge a request pulse
   output reg         irq_trigger_b,    // edge b request pulse
   output reg         compare_irq,      // compare match pulse
   output reg         cap_cmp_irq,      // capcmp match pulse
   output reg         timer_out_a,      // timer output pin a
   output reg         timer_out_b       // timer output pin b
);

   reg  [7:0]  timer_control;
   reg         overflow_flag;
   reg  [7:0]  capture_compare_control;
   reg  [7:0]  prescaler_mode_reg;
   reg  [7:0]  output_control_reg;
   reg  [15:0] count_reg;
   reg  [15:0] compare_reg;
   reg  [15:0] cap_cmp_reg;
   reg  [15:0] capture_reg;
   reg         started;
   reg         clr_pend;
   reg  [9:0]  pre_cnt;
   reg         pre_tick;
   reg  [1:0]  pin_s1;
   reg  [1:0]  pin_s2;
   reg  [1:0]  pin_d;
   reg  [1:0]  edge_evt;
   reg         match0_q;
   reg         match1_q;

   wire [1:0]  pins     = {trigger_input_b, trigger_input_a};
   wire [3:0]  edge_cfg = {edge_sel_b, edge_sel_a};
   wire        width_select    = timer_control[`CCT_TC_WIDTH];
   wire        one_shot_select = timer_control[`CCT_TC_ONESHOT];
   wire        count_enable    = timer_control[`CCT_TC_ENABLE];
   wire        cap_cmp_select  = capture_compare_control[`CCT_CC_CAPCMP_SEL];
   wire        match_clear_en  = capture_compare_control[`CCT_CC_MATCH_CLR];
   wire        capture_clear_en = capture_compare_control[`CCT_CC_CAPTURE_CLR];
   wire        out_mode_lo     = capture_compare_control[`CCT_CC_MODE_LO];
   wire        out_mode_hi     = capture_compare_control[`CCT_CC_MODE_HI];
   wire [1:0]  out_mode        = {out_mode_hi, out_mode_lo};
   wire [3:0]  pre_sel         = prescaler_mode_reg[7:4];

   // bus decode
   wire wr_tc   = bus_wr & (bus_addr == `CCT_ADDR_TIMER_CTRL);
   wire wr_cc   = bus_wr & (bus_addr == `CCT_ADDR_CAPCMP_CTRL);
   wire wr_pre  = bus_wr & (bus_addr == `CCT_ADDR_PRESCALER);
   wire wr_oc   = bus_wr & (bus_addr == `CCT_ADDR_OUTCTL);
   wire wr_c0lo = bus_wr & (bus_addr == `CCT_ADDR_COMPARE_LO);
   wire wr_c0hi = bus_wr & (bus_addr == `CCT_ADDR_COMPARE_HI);
   wire wr_c1lo = bus_wr & (bus_addr == `CCT_ADDR_CAPCMP_LO);
   wire wr_c1hi = bus_wr & (bus_addr == `CCT_ADDR_CAPCMP_HI);

   // width mask and counter arithmetic
   wire [15:0] wmask    = width_select ? 16'hffff : 16'h00ff;
   wire [15:0] cnt_inc  = (count_reg + 16'h0001) & wmask;
   wire        cnt_full = (count_reg == wmask);
   wire        running  = count_enable & started;
   wire        halted   = one_shot_select & overflow_flag;

   // count clock selection
   wire        ext_clk    = (pre_sel == `CCT_PRE_EXT_SEL);
   wire        count_tick = ext_clk ? edge_evt[1] : pre_tick;

   // capture triggers only while counting
   wire cap_a = running & edge_evt[0];
   wire cap_b = running & edge_evt[1] & cap_cmp_select;

   // match levels, gated off while stopped
   wire match0_lvl = running & (count_reg == (compare_reg & wmask));
   wire match1_lvl = running & ~cap_cmp_select & (count_reg == (cap_cmp_reg & wmask));
   wire match0_evt = match0_lvl & ~match0_q;
   wire match1_evt = match1_lvl & ~match1_q;

   // automatic clear sources
   wire clr_src = (match1_evt & match_clear_en)
                | (cap_a & capture_clear_en)
                | (cap_b & match_clear_en);

   // overflow event
   wire adv     = count_tick & running & ~clr_pend & ~halted;
   wire ovf_set = adv & (one_shot_select ? ((cnt_inc == wmask) & ~cnt_full)
                                         : cnt_full);
   wire tc_clr_ovf = wr_tc & ~bus_wdata[`CCT_TC_OVF];

   // prescaler divide mask: 4 << sel system clocks, sel above 8 taken as 8
   wire [3:0] pre_shift = (pre_sel > `CCT_PRE_MAX_SEL) ? 4'h0 : (`CCT_PRE_MAX_SEL - pre_sel);
   wire [9:0] pre_mask  = 10'h3ff >> pre_shift;

   // prescaler counter and tick pulse
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pre_cnt  <= 10'h000;
         pre_tick <= 1'b0;
      end else begin
         pre_cnt  <= pre_cnt + 10'h001;
         pre_tick <= ((pre_cnt & pre_mask) == pre_mask);
      end
   end

   // synchronisers and edge detectors per trigger input
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_edge
         wire rise = pin_s2[gi] & ~pin_d[gi];
         wire fall = ~pin_s2[gi] & pin_d[gi];
         always @(posedge core_clk or posedge rst) begin
            if (rst) begin
               pin_s1[gi]   <= 1'b0;
               pin_s2[gi]   <= 1'b0;
               pin_d[gi]    <= 1'b0;
               edge_evt[gi] <= 1'b0;
            end else begin
               pin_s1[gi]   <= pins[gi];
               pin_s2[gi]   <= pin_s1[gi];
               pin_d[gi]    <= pin_s2[gi];
               edge_evt[gi] <= (edge_cfg[2*gi] & rise) | (edge_cfg[2*gi+1] & fall);
            end
         end
      end
   endgenerate

   // control registers
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         timer_control           <= `CCT_RST_TIMER_CTRL;
         capture_compare_control <= `CCT_RST_CAPCMP_CTRL;
         prescaler_mode_reg      <= `CCT_RST_PRESCALER;
         output_control_reg      <= `CCT_RST_OUTCTL;
         overflow_flag           <= 1'b0;
      end else begin
         if (wr_tc)
            timer_control <= bus_wdata;
         if (wr_cc)
            capture_compare_control <= bus_wdata;
         if (wr_pre)
            prescaler_mode_reg <= bus_wdata;
         if (wr_oc)
            output_control_reg <= bus_wdata;
         // set beats a simultaneous software clear
         overflow_flag <= ovf_set | (overflow_flag & ~tc_clr_ovf);
      end
   end

   // counter, start sequence and auto clear
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         count_reg <= 16'h0000;
         started   <= 1'b0;
         clr_pend  <= 1'b0;
      end else if (wr_tc & ~bus_wdata[`CCT_TC_ENABLE]) begin
         count_reg <= 16'h0000;
         started   <= 1'b0;
         clr_pend  <= 1'b0;
      end else if (wr_tc & ~count_enable) begin
         count_reg <= 16'h0000;
         started   <= 1'b0;
         clr_pend  <= 1'b0;
      end else if (halted & tc_clr_ovf) begin
         count_reg <= 16'h0000;
         clr_pend  <= 1'b0;
      end else begin
         if (count_tick & count_enable & ~started) begin
            count_reg <= 16'h0000;
            started   <= 1'b1;
         end else if (count_tick & running & clr_pend) begin
            count_reg <= 16'h0000;
         end else if (adv & (halted | (one_shot_select & cnt_full))) begin
            count_reg <= count_reg;
         end else if (adv) begin
            count_reg <= cnt_inc;
         end
         // a clear source held until the next count tick
         if (clr_src)
            clr_pend <= 1'b1;
         else if (count_tick & running)
            clr_pend <= 1'b0;
      end
   end

   // compare, capcmp and capture registers
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         compare_reg <= 16'h0000;
         cap_cmp_reg <= 16'h0000;
         capture_reg <= 16'h0000;
      end else begin
         if (wr_c0lo)
            compare_reg[7:0] <= bus_wdata;
         if (wr_c0hi)
            compare_reg[15:8] <= bus_wdata;
         if (cap_b)
            cap_cmp_reg <= count_reg;
         else if (wr_c1lo)
            cap_cmp_reg[7:0] <= bus_wdata;
         else if (wr_c1hi)
            cap_cmp_reg[15:8] <= bus_wdata;
         if (cap_a)
            capture_reg <= count_reg;
      end
   end

   // match edge tracking and request pulses
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         match0_q      <= 1'b0;
         match1_q      <= 1'b0;
         irq_trigger_a <= 1'b0;
         irq_trigger_b <= 1'b0;
         compare_irq   <= 1'b0;
         cap_cmp_irq   <= 1'b0;
      end else begin
         match0_q      <= match0_lvl;
         match1_q      <= match1_lvl;
         irq_trigger_a <= edge_evt[0];
         irq_trigger_b <= edge_evt[1];
         compare_irq   <= match0_evt;
         cap_cmp_irq   <= match1_evt;
      end
   end

   // output control for both timer pins
   wire en_a  = output_control_reg[`CCT_OC_ENABLE_A];
   wire lvl_a = output_control_reg[`CCT_OC_LEVEL_A];
   wire en_b  = output_control_reg[`CCT_OC_ENABLE_B];
   wire lvl_b = output_control_reg[`CCT_OC_LEVEL_B];

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         timer_out_a <= 1'b0;
         timer_out_b <= 1'b0;
      end else begin
         if (~en_a) begin
            timer_out_a <= lvl_a;
         end else begin
            case (out_mode)
               2'b00: begin
                  if (match0_evt)
                     timer_out_a <= ~timer_out_a;
               end
               2'b01, 2'b10: begin
                  if (match0_evt)
                     timer_out_a <= lvl_a;
                  else if (ovf_set)
                     timer_out_a <= ~lvl_a;
               end
               2'b11: begin
                  if (match0_evt)
                     timer_out_a <= lvl_a;
                  else if (match1_evt)
                     timer_out_a <= ~lvl_a;
               end
               default: timer_out_a <= lvl_a;
            endcase
         end
         if (~en_b) begin
            timer_out_b <= lvl_b;
         end else if (out_mode == 2'b10) begin
            if (match1_evt)
               timer_out_b <= lvl_b;
            else if (ovf_set)
               timer_out_b <= ~lvl_b;
         end else if (match1_evt) begin
            timer_out_b <= ~timer_out_b;
         end
      end
   end

   // registered read data; counter and capture have no write path
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bus_rdata <= 8'h00;
      end else if (bus_rd) begin
         case (bus_addr)
            `CCT_ADDR_TIMER_CTRL:  bus_rdata <= {timer_control[7], overflow_flag,
                                                 timer_control[5:0]};
            `CCT_ADDR_CAPCMP_CTRL: bus_rdata <= capture_compare_control;
            `CCT_ADDR_PRESCALER:   bus_rdata <= prescaler_mode_reg;
            `CCT_ADDR_OUTCTL:      bus_rdata <= output_control_reg;
            `CCT_ADDR_COUNT_LO:    bus_rdata <= count_reg[7:0];
            `CCT_ADDR_COUNT_HI:    bus_rdata <= count_reg[15:8];
            `CCT_ADDR_COMPARE_LO:  bus_rdata <= compare_reg[7:0];
            `CCT_ADDR_COMPARE_HI:  bus_rdata <= compare_reg[15:8];
            `CCT_ADDR_CAPCMP_LO:   bus_rdata <= cap_cmp_reg[7:0];
            `CCT_ADDR_CAPCMP_HI:   bus_rdata <= cap_cmp_reg[15:8];
            `CCT_ADDR_CAPTURE_LO:  bus_rdata <= capture_reg[7:0];
            `CCT_ADDR_CAPTURE_HI:  bus_rdata <= capture_reg[15:8];
            default:               bus_rdata <= 8'h00;
         endcase
      end
   end

endmodule // cct_timer_core

// file: testbench/cct_timer_core_chk.sv
`timescale 1ns/1ps
`include "cct_defs.vh"
module cct_timer_core_chk (
   input wire        core_clk,        // system clock
   input wire        rst,             // async reset
   input wire [15:0] bus_addr,        // byte address
   input wire [7:0]  bus_wdata,       // write data
   input wire        bus_wr,          // write strobe
   input wire        bus_rd,          // read strobe
   input wire [7:0]  bus_rdata,       // read data
   input wire        trigger_input_a, // pin a
   input wire        trigger_input_b, // pin b
   input wire [1:0]  edge_sel_a,      // edge mode a
   input wire [1:0]  edge_sel_b,      // edge mode b
   input wire        irq_trigger_a,   // edge a pulse
   input wire        irq_trigger_b,   // edge b pulse
   input wire        compare_irq,     // compare pulse
   input wire        timer_out_a,     // output a
   input wire        timer_out_b      // output b
);
   reg [7:0] tc_sh;
   reg [7:0] cc_sh;
   reg [7:0] oc_sh;
   // shadows of software-written control bytes
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tc_sh <= 8'h00;
         cc_sh <= 8'h10;
         oc_sh <= 8'h00;
      end else if (bus_wr) begin
         if (bus_addr == `CCT_ADDR_TIMER_CTRL) tc_sh <= bus_wdata;
         if (bus_addr == `CCT_ADDR_CAPCMP_CTRL) cc_sh <= bus_wdata;
         if (bus_addr == `CCT_ADDR_OUTCTL) oc_sh <= bus_wdata;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   AST_IRQA_PULSE: assert property (irq_trigger_a |=> !irq_trigger_a)
      else $error("edge a request wider than one cycle");
   AST_IRQA_EDGE: assert property (($changed(trigger_input_a) && edge_sel_a == 2'b11)
      |-> ##[2:6] irq_trigger_a) else $error("edge a gave no request");
   AST_IRQB_EDGE: assert property (($changed(trigger_input_b) && edge_sel_b == 2'b11)
      |-> ##[2:6] irq_trigger_b) else $error("edge b gave no request");
   AST_CMP_PULSE: assert property (compare_irq |=> !compare_irq)
      else $error("compare request wider than one cycle");
   AST_OUTA_LEVEL: assert property ((!oc_sh[5] && $stable(oc_sh))
      |-> timer_out_a == oc_sh[4]) else $error("disabled output a not at level");
   AST_OUTB_LEVEL: assert property ((!oc_sh[7] && $stable(oc_sh))
      |-> timer_out_b == oc_sh[6]) else $error("disabled output b not at level");
   AST_TC_READ: assert property ((bus_rd && bus_addr == `CCT_ADDR_TIMER_CTRL)
      |=> (bus_rdata & 8'hbf) == ($past(tc_sh) & 8'hbf)) else $error("timer control lost");
   AST_CC_READ: assert property ((bus_rd && bus_addr == `CCT_ADDR_CAPCMP_CTRL)
      |=> bus_rdata == $past(cc_sh)) else $error("capcmp control lost");
   AST_STOP_ZERO: assert property ((bus_rd && bus_addr == `CCT_ADDR_COUNT_LO
      && !tc_sh[7] && !$past(tc_sh[7])) |=> bus_rdata == 8'h00)
      else $error("stopped counter not zero");
   // main scenarios reached
   C_IRQA: cover property (irq_trigger_a);
   C_CMP: cover property (compare_irq);
   C_OVF: cover property (bus_rd ##1 bus_rdata[6]);
endmodule // cct_timer_core_chk
bind cct_timer_core cct_timer_core_chk cct_timer_core_chk_i (.core_clk(core_clk), .rst(rst),
   .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
   .bus_rdata(bus_rdata), .trigger_input_a(trigger_input_a),
   .trigger_input_b(trigger_input_b), .edge_sel_a(edge_sel_a), .edge_sel_b(edge_sel_b),
   .irq_trigger_a(irq_trigger_a), .irq_trigger_b(irq_trigger_b),
   .compare_irq(compare_irq), .timer_out_a(timer_out_a), .timer_out_b(timer_out_b));

// file: testbench/cct_pins_model.sv
`timescale 1ns/1ps
module cct_pins_model (
   input  wire core_clk,        // system clock
   input  wire rst,             // async reset
   input  wire flip_a,          // make one edge on pin a
   input  wire flip_b,          // make one edge on pin b
   output reg  trigger_input_a, // driven pin a
   output reg  trigger_input_b  // driven pin b
);
   // each request flips a pin, which then stands until the next one
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         trigger_input_a <= 1'b0;
         trigger_input_b <= 1'b0;
      end else begin
         if (flip_a) trigger_input_a <= ~trigger_input_a;
         if (flip_b) trigger_input_b <= ~trigger_input_b;
      end
   end
endmodule // cct_pins_model

// file: testbench/cct_timer_core_tb.sv
`timescale 1ns/1ps
`include "cct_defs.vh"
`define CHK(g, e) begin n_checks = n_checks + 1; if ((g) !== (e)) begin \
   mismatches = mismatches + 1; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module cct_timer_core_tb;
   reg         core_clk, rst, bus_wr, bus_rd, flip_a, flip_b;
   reg  [15:0] bus_addr;
   reg  [7:0]  bus_wdata, rd_v;
   reg  [1:0]  edge_sel_a, edge_sel_b;
   wire [7:0]  bus_rdata;
   wire        pin_a, pin_b, irq_a, irq_b, cmp_irq, cc_irq, out_a, out_b;
   integer     mismatches, n_checks;
   reg  [7:0]  n_cmp = 8'h00;
   reg  [7:0]  n_cc = 8'h00;
   reg  [7:0]  base, base_cmp, base_cc;
   // count request pulses from the design
   always @(posedge core_clk) begin
      if (cmp_irq) n_cmp <= n_cmp + 8'h01;
      if (cc_irq) n_cc <= n_cc + 8'h01;
   end
   cct_timer_core cct_timer_core_i (.core_clk(core_clk), .rst(rst), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .trigger_input_a(pin_a), .trigger_input_b(pin_b), .edge_sel_a(edge_sel_a),
      .edge_sel_b(edge_sel_b), .irq_trigger_a(irq_a), .irq_trigger_b(irq_b),
      .compare_irq(cmp_irq), .cap_cmp_irq(cc_irq), .timer_out_a(out_a), .timer_out_b(out_b));
   cct_pins_model cct_pins_model_i (.core_clk(core_clk), .rst(rst), .flip_a(flip_a),
      .flip_b(flip_b), .trigger_input_a(pin_a), .trigger_input_b(pin_b));
   task wr(input [15:0] a, input [7:0] d);
      begin
         @(posedge core_clk);
         bus_addr <= a;
         bus_wdata <= d;
         bus_wr <= 1'b1;
         @(posedge core_clk);
         bus_wr <= 1'b0;
      end
   endtask
   task rd(input [15:0] a);
      begin
         @(posedge core_clk);
         bus_addr <= a;
         bus_rd <= 1'b1;
         @(posedge core_clk);
         bus_rd <= 1'b0;
         #1 rd_v = bus_rdata;
      end
   endtask
   // n edges on pin a or b, each held well beyond the sync delay
   task pulse(input on_a, input integer n);
      begin
         repeat (n) begin
            @(posedge core_clk);
            flip_a <= on_a;
            flip_b <= !on_a;
            @(posedge core_clk);
            flip_a <= 1'b0;
            flip_b <= 1'b0;
            repeat (8) @(posedge core_clk);
         end
      end
   endtask
   task end_sim;
      begin
         if (mismatches == 0 && n_checks > 0) $display("bench passed");
         else $display("bench failed");
         $finish;
      end
   endtask
   task t_reset;
      begin
         rd(`CCT_ADDR_TIMER_CTRL);
         `CHK(rd_v, 8'h00)
         rd(`CCT_ADDR_CAPCMP_CTRL);
         `CHK(rd_v, 8'h10)
         rd(`CCT_ADDR_COUNT_LO);
         `CHK(rd_v, 8'h00)
         rd(16'hff30);
         `CHK(rd_v, 8'h00)
      end
   endtask
   task t_start;
      begin
         wr(`CCT_ADDR_PRESCALER, 8'hf0);
         wr(`CCT_ADDR_TIMER_CTRL, 8'h80);
         pulse(1'b0, 1);
         rd(`CCT_ADDR_COUNT_LO);
         `CHK(rd_v, 8'h00)
         pulse(1'b0, 3);
         wr(`CCT_ADDR_TIMER_CTRL, 8'h80);
         wr(`CCT_ADDR_COUNT_LO, 8'h55);
         rd(`CCT_ADDR_COUNT_LO);
         `CHK(rd_v, 8'h03)
         pulse(1'b1, 1);
         wr(`CCT_ADDR_CAPTURE_LO, 8'h00);
         rd(`CCT_ADDR_CAPTURE_LO);
         `CHK(rd_v, 8'h03)
         wr(`CCT_ADDR_TIMER_CTRL, 8'h00);
         rd(`CCT_ADDR_COUNT_LO);
         `CHK(rd_v, 8'h00)
      end
   endtask
   task t_wrap;
      begin
         wr(`CCT_ADDR_TIMER_CTRL, 8'h80);
         pulse(1'b0, 257);
         rd(`CCT_ADDR_COUNT_LO);
         `CHK(rd_v, 8'h00)
         pulse(1'b0, 2);
         rd(`CCT_ADDR_TIMER_CTRL);
         `CHK(rd_v, 8'hc0)
         wr(`CCT_ADDR_TIMER_CTRL, 8'h80);
         rd(`CCT_ADDR_TIMER_CTRL);
         `CHK(rd_v, 8'h80)
         wr(`CCT_ADDR_TIMER_CTRL, 8'h00);
      end
   endtask
   task t_oneshot;
      begin
         wr(`CCT_ADDR_TIMER_CTRL, 8'ha0);
         pulse(1'b0, 258);
         rd(`CCT_ADDR_COUNT_LO);
         `CHK(rd_v, 8'hff)
         rd(`CCT_ADDR_TIMER_CTRL);
         `CHK(rd_v, 8'he0)
         wr(`CCT_ADDR_TIMER_CTRL, 8'ha0);
         pulse(1'b0, 1);
         rd(`CCT_ADDR_COUNT_LO);
         `CHK(rd_v, 8'h01)
         wr(`CCT_ADDR_TIMER_CTRL, 8'h00);
      end
   endtask
   task t_wide;
      begin
         wr(`CCT_ADDR_TIMER_CTRL, 8'h90);
         pulse(1'b0, 257);
         rd(`CCT_ADDR_COUNT_HI);
         `CHK(rd_v, 8'h01)
         wr(`CCT_ADDR_TIMER_CTRL, 8'h00);
      end
   endtask
   task t_capclr;
      begin
         wr(`CCT_ADDR_CAPCMP_CTRL, 8'h18);
         wr(`CCT_ADDR_TIMER_CTRL, 8'h80);
         pulse(1'b0, 3);
         pulse(1'b1, 1);
         rd(`CCT_ADDR_COUNT_LO);
         `CHK(rd_v, 8'h02)
         pulse(1'b0, 1);
         rd(`CCT_ADDR_COUNT_LO);
         `CHK(rd_v, 8'h00)
         wr(`CCT_ADDR_TIMER_CTRL, 8'h00);
      end
   endtask
   task t_match;
      begin
         wr(`CCT_ADDR_COMPARE_LO, 8'h04);
         wr(`CCT_ADDR_CAPCMP_LO, 8'h06);
         wr(`CCT_ADDR_CAPCMP_CTRL, 8'h14);
         wr(`CCT_ADDR_OUTCTL, 8'ha0);
         wr(`CCT_ADDR_TIMER_CTRL, 8'h80);
         base_cmp = n_cmp;
         base_cc = n_cc;
         pulse(1'b0, 7);
         rd(`CCT_ADDR_COUNT_LO);
         `CHK(rd_v, 8'h06)
         `CHK({out_a, out_b}, 2'b11)
         `CHK(n_cmp - base_cmp, 8'h01)
         `CHK(n_cc - base_cc, 8'h01)
         pulse(1'b0, 1);
         rd(`CCT_ADDR_COUNT_LO);
         `CHK(rd_v, 8'h00)
         wr(`CCT_ADDR_OUTCTL, 8'h10);
         repeat (3) @(posedge core_clk);
         `CHK({out_a, out_b}, 2'b10)
         wr(`CCT_ADDR_TIMER_CTRL, 8'h00);
      end
   endtask
   // both outputs pwm: match sets level, overflow inverts it
   task t_pwm;
      begin
         wr(`CCT_ADDR_CAPCMP_CTRL, 8'h50);
         wr(`CCT_ADDR_OUTCTL, 8'ha0);
         wr(`CCT_ADDR_TIMER_CTRL, 8'h80);
         pulse(1'b0, 7);
         `CHK({out_a, out_b}, 2'b00)
         pulse(1'b0, 250);
         `CHK({out_a, out_b}, 2'b11)
         wr(`CCT_ADDR_TIMER_CTRL, 8'h00);
      end
   endtask
   // capcmp captures on b edges, then counter steps on rising edges only
   task t_capb;
      begin
         wr(`CCT_ADDR_CAPCMP_CTRL, 8'h11);
         wr(`CCT_ADDR_TIMER_CTRL, 8'h80);
         pulse(1'b0, 4);
         rd(`CCT_ADDR_CAPCMP_LO);
         `CHK(rd_v, 8'h02)
         @(posedge core_clk);
         edge_sel_b <= 2'b01;
         pulse(1'b0, 2);
         rd(`CCT_ADDR_COUNT_LO);
         `CHK(rd_v, 8'h04)
         @(posedge core_clk);
         edge_sel_b <= 2'b11;
         wr(`CCT_ADDR_TIMER_CTRL, 8'h00);
      end
   endtask
   // internal clock divided by four: ten ticks in forty cycles
   task t_presc;
      begin
         wr(`CCT_ADDR_PRESCALER, 8'h00);
         wr(`CCT_ADDR_TIMER_CTRL, 8'h80);
         repeat (8) @(posedge core_clk);
         rd(`CCT_ADDR_COUNT_LO);
         base = rd_v;
         repeat (38) @(posedge core_clk);
         rd(`CCT_ADDR_COUNT_LO);
         `CHK(rd_v - base, 8'h0a)
         wr(`CCT_ADDR_TIMER_CTRL, 8'h00);
      end
   endtask
   // clock and watchdog
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   initial begin
      repeat (30000) @(posedge core_clk);
      mismatches = mismatches + 1;
      end_sim;
   end
   // main sequence
   initial begin
      {rst, bus_wr, bus_rd, flip_a, flip_b} = 5'h10;
      {bus_addr, bus_wdata} = 24'h000000;
      {edge_sel_a, edge_sel_b} = 4'hf;
      mismatches = 0;
      n_checks = 0;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      t_reset;
      t_start;
      t_wrap;
      t_oneshot;
      t_wide;
      t_capclr;
      t_match;
      t_pwm;
      t_capb;
      t_presc;
      end_sim;
   end
endmodule // cct_timer_core_tb
